// File: lod_decoder.v
// byte-serial decoder for control transfer, processor and protection control
// assumes a fetch unit offering one byte per cycle with valid/ready; one clock
// Operation
// - near/far returns C3,C2,CB,CA; stack-release forms carry 16-bit immediate low first
// - signed branches 7C,7E,7D,7F each with one displacement byte
// - unsigned branches 72,76,73,77 each with one displacement byte
// - single-flag branches 74,75,7A,7B,70,71,78,79 with displacement byte
// - count branches E2,E1,E0,E3 with displacement byte
// - procedure entry C8 with 16-bit frame size then level; exit C9
// - interrupts CD with type, CC type 3, CE on overflow, CF return
// - bounds check 62 followed by addressing-form byte
// - F0 lock prefix for next instruction, F4 halt, 9B wait
// - 0F 06 clears task-switched flag
// - 11011TTT escape; low bits plus register field form coprocessor code
// - 0F 01 register field selects global, interrupt table and status word ops
// - 0F 00 register field selects local table, task register, verify ops
// - 0F 02 and 0F 03 with addressing form; 63 adjusts privilege
// - mode 11 register, 00 no displacement, 01 one sign-extended, 10 two
// - operand-select field chooses base/frame/index terms plus displacement
// - mode 00 with select 110 gives direct 16-bit address
// - displacement bytes follow second byte, ahead of immediate data
// - 001rr110 segment override: 00 extra, 01 code, 10 stack, 11 data
// - register field maps to word or byte registers by width bit
// - frame-pointer addressed operands default to stack segment
// - string destination through destination index always uses extra segment
`include "lod_regs.vh"
module lod_decoder (
  input wire clk,
  input wire rst_n,
  input wire [7:0] byteIn,
  input wire byteValid,
  output wire byteReady,
  input wire wordWidth,
  input wire strDest,
  output wire decValid,
  input wire decReady,
  output reg [5:0] opId,
  output reg [3:0] condCode,
  output reg [5:0] escCode,
  output reg [7:0] intType,
  output reg [15:0] immData,
  output reg [7:0] nestLevel,
  output reg [15:0] dispVal,
  output reg [3:0] eaTerms,
  output reg eaDirect,
  output reg eaIsReg,
  output reg [3:0] regSel,
  output reg [3:0] rmSel,
  output reg [1:0] segSel,
  output reg lockPrefix,
  output reg undefOp
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam ST_OP = 3'h0;
  localparam ST_EXT = 3'h1;
  localparam ST_MODRM = 3'h2;
  localparam ST_DISPL = 3'h3;
  localparam ST_DISPH = 3'h4;
  localparam ST_IMML = 3'h5;
  localparam ST_IMMH = 3'h6;
  localparam ST_DONE = 3'h7;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [1:0] segOvr_q;
  reg segOvrValid_q;
  reg [7:0] ext_q;
  reg [1:0] immLeft_q;
  reg levelPending_q;
  reg [1:0] dispLeft_q;
  reg fromExt_q;

  assign byteReady = (state_q != ST_DONE);
  assign decValid = (state_q == ST_DONE);
  wire take = byteValid && byteReady;
  wire [1:0] mode = byteIn[7:6];
  wire [2:0] fld = byteIn[5:3];
  wire [2:0] rm = byteIn[2:0];

  // bytes owed after the opcode: one for branches, loops, int type; two for releases and the entry frame size
  wire [1:0] immCount = (byteIn[7:4] == 4'h7 || byteIn[7:2] == 6'h38 || byteIn == `LOD_OP_INTN) ? 2'h1 :
    (byteIn == `LOD_OP_RET_NEAR_IMM || byteIn == `LOD_OP_RET_FAR_IMM || byteIn == `LOD_OP_ENTER) ? 2'h2 : 2'h0;
  // eaTerms lags by one edge when the addressing byte is the last one
  wire frameUse = (state_q == ST_MODRM) ?
    (mode != 2'h3 && (rm == 3'h2 || rm == 3'h3 || (rm == 3'h6 && mode != 2'h0))) :
    (state_q != ST_OP && eaTerms[2] && !eaIsReg);

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_OP;
      segOvr_q <= 2'h0;
      segOvrValid_q <= 1'b0;
      ext_q <= 8'h00;
      immLeft_q <= 2'h0;
      levelPending_q <= 1'b0;
      dispLeft_q <= 2'h0;
      fromExt_q <= 1'b0;
      opId <= `LOD_ID_NONE;
      condCode <= 4'h0;
      escCode <= 6'h00;
      intType <= 8'h00;
      immData <= 16'h0000;
      nestLevel <= 8'h00;
      dispVal <= 16'h0000;
      eaTerms <= 4'h0;
      eaDirect <= 1'b0;
      eaIsReg <= 1'b0;
      regSel <= 4'h0;
      rmSel <= 4'h0;
      segSel <= `LOD_SEG_DS;
      lockPrefix <= 1'b0;
      undefOp <= 1'b0;
    end else begin
      state_q <= state_d;
      if (take) begin
        case (state_q)
          ST_OP: begin
            undefOp <= 1'b0;
            immLeft_q <= immCount;
            levelPending_q <= (byteIn == `LOD_OP_ENTER);
            dispLeft_q <= 2'h0;
            eaTerms <= 4'h0;
            eaDirect <= 1'b0;
            eaIsReg <= 1'b0;
            dispVal <= 16'h0000;
            fromExt_q <= 1'b0;
            condCode <= byteIn[3:0];
            if (byteIn[7:5] == 3'h1 && byteIn[2:0] == 3'h6) begin
              segOvr_q <= byteIn[4:3];
              segOvrValid_q <= 1'b1;
            end else if (byteIn == `LOD_OP_LOCK) begin
              lockPrefix <= 1'b1;
            end else if (byteIn[7:4] == 4'h7) begin
              opId <= `LOD_ID_JCC;
            end else if (byteIn[7:3] == `LOD_OP_ESC_HI) begin
              opId <= `LOD_ID_ESC;
              escCode <= {byteIn[2:0], 3'h0};
            end else begin
              case (byteIn)
                `LOD_OP_RET_NEAR: opId <= `LOD_ID_RET_NEAR;
                `LOD_OP_RET_FAR: opId <= `LOD_ID_RET_FAR;
                `LOD_OP_RET_NEAR_IMM: opId <= `LOD_ID_RET_NEAR_IMM;
                `LOD_OP_RET_FAR_IMM: opId <= `LOD_ID_RET_FAR_IMM;
                `LOD_OP_LOOPC: opId <= `LOD_ID_LOOPC;
                `LOD_OP_LOOPZ: opId <= `LOD_ID_LOOPZ;
                `LOD_OP_LOOPNZ: opId <= `LOD_ID_LOOPNZ;
                `LOD_OP_JCZ: opId <= `LOD_ID_JCZ;
                `LOD_OP_ENTER: opId <= `LOD_ID_ENTER;
                `LOD_OP_LEAVE: opId <= `LOD_ID_LEAVE;
                `LOD_OP_INTN: opId <= `LOD_ID_INTN;
                `LOD_OP_INT3: begin
                  opId <= `LOD_ID_INTN;
                  intType <= `LOD_INT3_TYPE;
                end
                `LOD_OP_INTO: opId <= `LOD_ID_INTO;
                `LOD_OP_INTERRUPT_RETURN: opId <= `LOD_ID_INTERRUPT_RETURN;
                `LOD_OP_BOUND: opId <= `LOD_ID_BOUND;
                `LOD_OP_ADJUST_REQUESTED_PRIVILEGE: opId <= `LOD_ID_ADJUST_REQUESTED_PRIVILEGE;
                `LOD_OP_HALT: opId <= `LOD_ID_HALT;
                `LOD_OP_WAIT: opId <= `LOD_ID_WAIT;
                `LOD_OP_EXT: opId <= `LOD_ID_NONE;
                default: begin
                  opId <= `LOD_ID_NONE;
                  undefOp <= 1'b1;
                end
              endcase
            end
          end
          ST_EXT: begin
            ext_q <= byteIn;
            fromExt_q <= 1'b1;
            case (byteIn)
              `LOD_EXT_CTS: opId <= `LOD_ID_CTS;
              `LOD_EXT_LAR: opId <= `LOD_ID_LAR;
              `LOD_EXT_LSL: opId <= `LOD_ID_LSL;
              `LOD_EXT_GRP0, `LOD_EXT_GRP1: opId <= `LOD_ID_NONE;
              default: undefOp <= 1'b1;
            endcase
          end
          ST_MODRM: begin
            regSel <= {~wordWidth, fld};
            rmSel <= {~wordWidth, rm};
            if (opId == `LOD_ID_ESC) begin
              escCode <= {escCode[5:3], fld};
            end
            if (fromExt_q && ext_q == `LOD_EXT_GRP1) begin
              case (fld)
                3'h0: opId <= `LOD_ID_SGDT;
                3'h1: opId <= `LOD_ID_SIDT;
                3'h2: opId <= `LOD_ID_LOAD_GLOBAL_TABLE;
                3'h3: opId <= `LOD_ID_LOAD_INTERRUPT_TABLE;
                3'h4: opId <= `LOD_ID_SMSW;
                3'h6: opId <= `LOD_ID_LOAD_MACHINE_STATUS;
                default: undefOp <= 1'b1;
              endcase
            end else if (fromExt_q && ext_q == `LOD_EXT_GRP0) begin
              case (fld)
                3'h0: opId <= `LOD_ID_SLDT;
                3'h1: opId <= `LOD_ID_STR;
                3'h2: opId <= `LOD_ID_LOAD_LOCAL_TABLE;
                3'h3: opId <= `LOD_ID_LTR;
                3'h4: opId <= `LOD_ID_VERIFY_READABLE;
                3'h5: opId <= `LOD_ID_VERIFY_WRITABLE;
                default: undefOp <= 1'b1;
              endcase
            end
            eaIsReg <= (mode == 2'h3);
            if (mode != 2'h3) begin
              case (rm)
                3'h0: eaTerms <= `LOD_EA_BASE | `LOD_EA_SRC;
                3'h1: eaTerms <= `LOD_EA_BASE | `LOD_EA_DST;
                3'h2: eaTerms <= `LOD_EA_FRAME | `LOD_EA_SRC;
                3'h3: eaTerms <= `LOD_EA_FRAME | `LOD_EA_DST;
                3'h4: eaTerms <= `LOD_EA_SRC;
                3'h5: eaTerms <= `LOD_EA_DST;
                3'h6: eaTerms <= (mode == 2'h0) ? 4'h0 : `LOD_EA_FRAME;
                default: eaTerms <= `LOD_EA_BASE;
              endcase
            end
            eaDirect <= (mode == 2'h0) && (rm == 3'h6);
            if (mode == 2'h1) begin
              dispLeft_q <= 2'h1;
            end else if (mode == 2'h2 || (mode == 2'h0 && rm == 3'h6)) begin
              dispLeft_q <= 2'h2;
            end else begin
              dispLeft_q <= 2'h0;
            end
          end
          ST_DISPL: begin
            // one-byte form is sign-extended; a high byte overwrites the top
            dispVal <= {{8{byteIn[7]}}, byteIn};
            dispLeft_q <= dispLeft_q - 2'h1;
          end
          ST_DISPH: begin
            dispVal[15:8] <= byteIn;
            dispLeft_q <= 2'h0;
          end
          ST_IMML: begin
            if (levelPending_q && immLeft_q == 2'h0) begin
              nestLevel <= byteIn;
              levelPending_q <= 1'b0;
            end else if (opId == `LOD_ID_INTN) begin
              intType <= byteIn;
              immLeft_q <= 2'h0;
            end else begin
              immData <= {{8{byteIn[7]}}, byteIn};
              immLeft_q <= immLeft_q - 2'h1;
            end
          end
          ST_IMMH: begin
            immData[15:8] <= byteIn;
            immLeft_q <= 2'h0;
          end
          default: begin
          end
        endcase
      end
      if (state_q == ST_DONE && decReady) begin
        segOvrValid_q <= 1'b0;
        lockPrefix <= 1'b0;
      end
      if (state_d == ST_DONE && state_q != ST_DONE) begin
        // stack default for frame terms, extra for string destination
        if (strDest) begin
          segSel <= `LOD_SEG_ES;
        end else if (segOvrValid_q) begin
          segSel <= segOvr_q;
        end else if (frameUse) begin
          segSel <= `LOD_SEG_SS;
        end else begin
          segSel <= `LOD_SEG_DS;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // next state: modrm, then displacement; immediate only straight after the opcode
  // ----------------------------------------------------------------
  wire needModrm = (opId == `LOD_ID_BOUND) || (opId == `LOD_ID_ADJUST_REQUESTED_PRIVILEGE) || (opId == `LOD_ID_ESC) ||
    (opId == `LOD_ID_LAR) || (opId == `LOD_ID_LSL);
  always @* begin
    state_d = state_q;
    if (state_q == ST_DONE) begin
      if (decReady) begin
        state_d = ST_OP;
      end
    end else if (take) begin
      case (state_q)
        ST_OP: begin
          if ((byteIn[7:5] == 3'h1 && byteIn[2:0] == 3'h6) || byteIn == `LOD_OP_LOCK) begin
            state_d = ST_OP;
          end else if (byteIn == `LOD_OP_EXT) begin
            state_d = ST_EXT;
          end else if (byteIn == `LOD_OP_BOUND || byteIn == `LOD_OP_ADJUST_REQUESTED_PRIVILEGE || byteIn[7:3] == `LOD_OP_ESC_HI) begin
            state_d = ST_MODRM;
          end else if (immCount != 2'h0) begin
            state_d = ST_IMML;
          end else begin
            state_d = ST_DONE;
          end
        end
        ST_EXT: state_d = (byteIn <= `LOD_EXT_LSL) ? ST_MODRM : ST_DONE;
        ST_MODRM: begin
          if (!undefOp && (needModrm || fromExt_q) && ((mode[0] ^ mode[1]) || (mode == 2'h0 && rm == 3'h6))) begin
            state_d = ST_DISPL;
          end else begin
            state_d = ST_DONE;
          end
        end
        ST_DISPL: state_d = (dispLeft_q == 2'h2) ? ST_DISPH : ST_DONE;
        ST_DISPH: state_d = ST_DONE;
        ST_IMML: begin
          if (immLeft_q == 2'h2) begin
            state_d = ST_IMMH;
          end else if (levelPending_q && immLeft_q != 2'h0) begin
            state_d = ST_IMML;
          end else begin
            state_d = ST_DONE;
          end
        end
        ST_IMMH: state_d = levelPending_q ? ST_IMML : ST_DONE;
        default: state_d = ST_OP;
      endcase
    end
  end
endmodule // lod_decoder

// File: lod_regs.vh
// opcode and field encodings for the legacy opcode decoder
// included by the decoder, its checker and its bench
`ifndef LOD_REGS_VH
`define LOD_REGS_VH
`define LOD_OP_RET_NEAR 8'hC3
`define LOD_OP_RET_NEAR_IMM 8'hC2
`define LOD_OP_RET_FAR 8'hCB
`define LOD_OP_RET_FAR_IMM 8'hCA
`define LOD_OP_JL 8'h7C
`define LOD_OP_JLE 8'h7E
`define LOD_OP_JNL 8'h7D
`define LOD_OP_JG 8'h7F
`define LOD_OP_BLW 8'h72
`define LOD_OP_BLE 8'h76
`define LOD_OP_NBL 8'h73
`define LOD_OP_ABV 8'h77
`define LOD_OP_JZ 8'h74
`define LOD_OP_JNZ 8'h75
`define LOD_OP_JPE 8'h7A
`define LOD_OP_JPO 8'h7B
`define LOD_OP_JOV 8'h70
`define LOD_OP_JNOV 8'h71
`define LOD_OP_JNEG 8'h78
`define LOD_OP_JPOS 8'h79
`define LOD_OP_LOOPC 8'hE2
`define LOD_OP_LOOPZ 8'hE1
`define LOD_OP_LOOPNZ 8'hE0
`define LOD_OP_JCZ 8'hE3
`define LOD_OP_ENTER 8'hC8
`define LOD_OP_LEAVE 8'hC9
`define LOD_OP_INTN 8'hCD
`define LOD_OP_INT3 8'hCC
`define LOD_OP_INTO 8'hCE
`define LOD_OP_INTERRUPT_RETURN 8'hCF
`define LOD_OP_BOUND 8'h62
`define LOD_OP_ADJUST_REQUESTED_PRIVILEGE 8'h63
`define LOD_OP_LOCK 8'hF0
`define LOD_OP_HALT 8'hF4
`define LOD_OP_WAIT 8'h9B
`define LOD_OP_EXT 8'h0F
`define LOD_OP_ESC_HI 5'h1B
`define LOD_EXT_GRP0 8'h00
`define LOD_EXT_GRP1 8'h01
`define LOD_EXT_LAR 8'h02
`define LOD_EXT_LSL 8'h03
`define LOD_EXT_CTS 8'h06
`define LOD_INT3_TYPE 8'h03
// operation identifiers
`define LOD_ID_NONE 6'h00
`define LOD_ID_RET_NEAR 6'h01
`define LOD_ID_RET_NEAR_IMM 6'h02
`define LOD_ID_RET_FAR 6'h03
`define LOD_ID_RET_FAR_IMM 6'h04
`define LOD_ID_JCC 6'h05
`define LOD_ID_LOOPC 6'h06
`define LOD_ID_LOOPZ 6'h07
`define LOD_ID_LOOPNZ 6'h08
`define LOD_ID_JCZ 6'h09
`define LOD_ID_ENTER 6'h0A
`define LOD_ID_LEAVE 6'h0B
`define LOD_ID_INTN 6'h0C
`define LOD_ID_INTO 6'h0D
`define LOD_ID_INTERRUPT_RETURN 6'h0E
`define LOD_ID_BOUND 6'h0F
`define LOD_ID_HALT 6'h10
`define LOD_ID_WAIT 6'h11
`define LOD_ID_CTS 6'h12
`define LOD_ID_ESC 6'h13
`define LOD_ID_SGDT 6'h14
`define LOD_ID_SIDT 6'h15
`define LOD_ID_LOAD_GLOBAL_TABLE 6'h16
`define LOD_ID_LOAD_INTERRUPT_TABLE 6'h17
`define LOD_ID_SMSW 6'h18
`define LOD_ID_LOAD_MACHINE_STATUS 6'h19
`define LOD_ID_SLDT 6'h1A
`define LOD_ID_STR 6'h1B
`define LOD_ID_LOAD_LOCAL_TABLE 6'h1C
`define LOD_ID_LTR 6'h1D
`define LOD_ID_VERIFY_READABLE 6'h1E
`define LOD_ID_VERIFY_WRITABLE 6'h1F
`define LOD_ID_LAR 6'h20
`define LOD_ID_LSL 6'h21
`define LOD_ID_ADJUST_REQUESTED_PRIVILEGE 6'h22
// segment codes
`define LOD_SEG_ES 2'h0
`define LOD_SEG_CS 2'h1
`define LOD_SEG_SS 2'h2
`define LOD_SEG_DS 2'h3
// effective-address term bits: {base,frame,source,destination}
`define LOD_EA_BASE 4'h8
`define LOD_EA_FRAME 4'h4
`define LOD_EA_SRC 4'h2
`define LOD_EA_DST 4'h1
`endif

// File: lod_decoder_sva.sv
// port-level checks for the opcode decoder
// assumes one clock and the asynchronous active-low reset
`include "lod_regs.vh"
module lod_decoder_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] byteIn,
  input wire logic byteValid,
  input wire logic byteReady,
  input wire logic strDest,
  input wire logic decValid,
  input wire logic decReady,
  input wire logic [5:0] opId,
  input wire logic [3:0] condCode,
  input wire logic [5:0] escCode,
  input wire logic [7:0] intType,
  input wire logic [3:0] eaTerms,
  input wire logic [1:0] segSel,
  input wire logic lockPrefix,
  input wire logic undefOp
);
  timeunit 1ns;
  timeprecision 1ns;
  logic expectFirst_q;
  logic [7:0] firstByte_q;
  wire taken = byteValid && byteReady;
  // first byte of each instruction, so results can be tied to their cause
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      expectFirst_q <= 1'b1;
      firstByte_q <= 8'h00;
    end else begin
      if (taken && expectFirst_q) begin
        firstByte_q <= byteIn;
        expectFirst_q <= 1'b0;
      end
      if (decValid && decReady) begin
        expectFirst_q <= 1'b1;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_near_ret;
    taken && expectFirst_q && byteIn == `LOD_OP_RET_NEAR |=> decValid && opId == `LOD_ID_RET_NEAR;
  endproperty
  a_near_ret: assert property (p_near_ret) else $error("near return not answered next cycle");
  property p_far_ret;
    $rose(decValid) && firstByte_q == `LOD_OP_RET_FAR |-> opId == `LOD_ID_RET_FAR;
  endproperty
  a_far_ret: assert property (p_far_ret) else $error("far return misdecoded");
  property p_cond;
    $rose(decValid) && firstByte_q[7:4] == 4'h7 |-> opId == `LOD_ID_JCC && condCode == firstByte_q[3:0];
  endproperty
  a_cond: assert property (p_cond) else $error("conditional branch misdecoded");
  property p_int3;
    $rose(decValid) && firstByte_q == `LOD_OP_INT3 |-> intType == `LOD_INT3_TYPE;
  endproperty
  a_int3: assert property (p_int3) else $error("breakpoint type wrong");
  property p_halt;
    taken && expectFirst_q && byteIn == `LOD_OP_HALT |=> decValid && opId == `LOD_ID_HALT;
  endproperty
  a_halt: assert property (p_halt) else $error("halt misdecoded");
  property p_lock;
    $rose(decValid) && firstByte_q == `LOD_OP_LOCK |-> lockPrefix;
  endproperty
  a_lock: assert property (p_lock) else $error("lock prefix lost");
  property p_esc;
    $rose(decValid) && firstByte_q[7:3] == `LOD_OP_ESC_HI |-> opId == `LOD_ID_ESC && escCode[5:3] == firstByte_q[2:0];
  endproperty
  a_esc: assert property (p_esc) else $error("escape code wrong");
  property p_undef;
    $rose(decValid) && firstByte_q == 8'h00 |-> undefOp;
  endproperty
  a_undef: assert property (p_undef) else $error("undefined opcode not flagged");
  property p_frame_stack;
    $rose(decValid) && firstByte_q == `LOD_OP_BOUND && eaTerms[2] && !$past(strDest) |-> segSel == `LOD_SEG_SS;
  endproperty
  a_frame_stack: assert property (p_frame_stack) else $error("frame operand not on stack segment");
  property p_str_dest;
    $rose(decValid) && $past(strDest) && eaTerms == `LOD_EA_DST |-> segSel == `LOD_SEG_ES;
  endproperty
  a_str_dest: assert property (p_str_dest) else $error("string destination not on extra segment");
  c_esc: cover property ($rose(decValid) && opId == `LOD_ID_ESC);
  c_lock: cover property (decValid && lockPrefix);
  c_extra: cover property ($rose(decValid) && segSel == `LOD_SEG_ES);
endmodule // lod_decoder_sva

bind lod_decoder lod_decoder_sva u_sva (.clk(clk), .rst_n(rst_n), .byteIn(byteIn), .byteValid(byteValid),
  .byteReady(byteReady), .strDest(strDest), .decValid(decValid), .decReady(decReady), .opId(opId),
  .condCode(condCode), .escCode(escCode), .intType(intType), .eaTerms(eaTerms), .segSel(segSel),
  .lockPrefix(lockPrefix), .undefOp(undefOp));

// File: lod_fetch_model.sv
// behavioural fetch unit offering instruction bytes one at a time
// assumes the bench fills fifo and may set slow to space the bytes out
module lod_fetch_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic byteReady,
  output logic [7:0] byteIn,
  output logic byteValid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] fifo[$];
  int slow = 0;
  int gap = 0;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byteValid <= 1'b0;
      byteIn <= 8'h5A;
      gap = 0;
    end else if (!(byteValid && !byteReady)) begin
      if (byteValid) begin
        void'(fifo.pop_front());
      end
      if (fifo.size() != 0 && gap == 0) begin
        byteValid <= 1'b1;
        byteIn <= fifo[0];
        gap = slow;
      end else begin
        // idle bus toggles so a stale byte never looks like a fresh one
        byteValid <= 1'b0;
        byteIn <= ~byteIn;
        if (gap != 0) gap--;
      end
    end
  end
endmodule // lod_fetch_model

// File: lod_decoder_tb_top.sv
// self-checking bench for the opcode decoder
// assumes lod_fetch_model as byte source and the bound checker
`include "lod_regs.vh"
module lod_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wordWidth = 1'b1;
  logic strDest = 1'b0;
  logic decReady = 1'b0;
  wire [7:0] byteIn, intType, nestLevel;
  wire byteValid, byteReady, decValid, eaDirect, eaIsReg, lockPrefix, undefOp;
  wire [5:0] opId, escCode;
  wire [3:0] condCode, eaTerms, regSel, rmSel;
  wire [15:0] immData, dispVal;
  wire [1:0] segSel;
  int miscompares = 0;
  int samples_checked = 0;
  always #50 clk = ~clk;
  lod_fetch_model fetch (.clk(clk), .rst_n(rst_n), .byteReady(byteReady), .byteIn(byteIn), .byteValid(byteValid));
  lod_decoder dut (.clk(clk), .rst_n(rst_n), .byteIn(byteIn), .byteValid(byteValid), .byteReady(byteReady),
    .wordWidth(wordWidth), .strDest(strDest), .decValid(decValid), .decReady(decReady), .opId(opId),
    .condCode(condCode), .escCode(escCode), .intType(intType), .immData(immData), .nestLevel(nestLevel),
    .dispVal(dispVal), .eaTerms(eaTerms), .eaDirect(eaDirect), .eaIsReg(eaIsReg), .regSel(regSel),
    .rmSel(rmSel), .segSel(segSel), .lockPrefix(lockPrefix), .undefOp(undefOp));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic send(input logic [7:0] b[$]);
    int n;
    foreach (b[i]) fetch.fifo.push_back(b[i]);
    n = 0;
    while (decValid !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (decValid !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED t=%0t no result", $time);
      end_of_test();
    end
  endtask
  // result must stand and new bytes be refused until accepted
  task automatic accept;
    repeat (2) begin
      @(posedge clk);
      #1;
      chk(byteReady, 1'b0, "refuse");
      chk(decValid, 1'b1, "held");
    end
    @(posedge clk) decReady <= 1'b1;
    @(posedge clk) decReady <= 1'b0;
    #1;
    chk(decValid, 1'b0, "released");
  endtask
  task automatic one(input logic [7:0] b[$], input logic [5:0] id);
    send(b);
    chk(opId, id, "op");
    accept();
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_returns;
    one('{8'hC3}, `LOD_ID_RET_NEAR);
    one('{8'hCB}, `LOD_ID_RET_FAR);
    fetch.slow = 3;
    send('{8'hC2, 8'h34, 8'h12});
    chk(opId, `LOD_ID_RET_NEAR_IMM, "ret imm");
    chk(immData, 16'h1234, "ret release");
    accept();
    fetch.slow = 0;
    send('{8'hCA, 8'hCD, 8'hAB});
    chk(opId, `LOD_ID_RET_FAR_IMM, "far imm");
    chk(immData, 16'hABCD, "far release");
    accept();
    $display("test returns done");
  endtask
  task automatic t_branches;
    for (int i = 0; i < 16; i++) begin
      send('{{4'h7, i[3:0]}, 8'h80});
      chk(opId, `LOD_ID_JCC, "cond op");
      chk(condCode, i[3:0], "cond code");
      chk(immData, 16'hFF80, "cond disp");
      accept();
    end
    one('{8'hE2, 8'h05}, `LOD_ID_LOOPC);
    one('{8'hE1, 8'h05}, `LOD_ID_LOOPZ);
    one('{8'hE0, 8'h05}, `LOD_ID_LOOPNZ);
    one('{8'hE3, 8'h05}, `LOD_ID_JCZ);
    $display("test branches done");
  endtask
  task automatic t_frames;
    send('{8'hC8, 8'h00, 8'h01, 8'h03});
    chk(opId, `LOD_ID_ENTER, "entry");
    chk(immData, 16'h0100, "frame size");
    chk(nestLevel, 8'h03, "level");
    accept();
    one('{8'hC9}, `LOD_ID_LEAVE);
    send('{8'hCD, 8'h21});
    chk(intType, 8'h21, "int type");
    accept();
    send('{8'hCC});
    chk(opId, `LOD_ID_INTN, "breakpoint");
    chk(intType, `LOD_INT3_TYPE, "type 3");
    accept();
    one('{8'hCE}, `LOD_ID_INTO);
    one('{8'hCF}, `LOD_ID_INTERRUPT_RETURN);
    $display("test frames done");
  endtask
  task automatic t_control;
    one('{8'hF4}, `LOD_ID_HALT);
    one('{8'h9B}, `LOD_ID_WAIT);
    send('{8'hF0, 8'hC9});
    chk(lockPrefix, 1'b1, "lock");
    accept();
    send('{8'hC9});
    chk(lockPrefix, 1'b0, "lock gone");
    accept();
    one('{8'h0F, 8'h06}, `LOD_ID_CTS);
    $display("test control done");
  endtask
  task automatic t_protect;
    logic [5:0] tbl[2][8] = '{'{`LOD_ID_SGDT, `LOD_ID_SIDT, `LOD_ID_LOAD_GLOBAL_TABLE, `LOD_ID_LOAD_INTERRUPT_TABLE, `LOD_ID_SMSW, 6'h00,
      `LOD_ID_LOAD_MACHINE_STATUS, 6'h00}, '{`LOD_ID_SLDT, `LOD_ID_STR, `LOD_ID_LOAD_LOCAL_TABLE, `LOD_ID_LTR, `LOD_ID_VERIFY_READABLE,
      `LOD_ID_VERIFY_WRITABLE, 6'h00, 6'h00}};
    for (int g = 0; g < 2; g++) begin
      for (int r = 0; r < 8; r++) begin
        send('{8'h0F, (g == 0) ? 8'h01 : 8'h00, {2'b11, r[2:0], 3'b001}});
        if (tbl[g][r] == 6'h00) chk(undefOp, 1'b1, "bad field");
        else chk(opId, tbl[g][r], "group op");
        accept();
      end
    end
    one('{8'h0F, 8'h02, 8'hC1}, `LOD_ID_LAR);
    one('{8'h0F, 8'h03, 8'hC1}, `LOD_ID_LSL);
    one('{8'h63, 8'hC1}, `LOD_ID_ADJUST_REQUESTED_PRIVILEGE);
    one('{8'h62, 8'h07}, `LOD_ID_BOUND);
    $display("test protection done");
  endtask
  task automatic t_address;
    logic [3:0] ea[8] = '{4'hA, 4'h9, 4'h6, 4'h5, 4'h2, 4'h1, 4'h4, 4'h8};
    for (int r = 0; r < 8; r++) begin
      @(posedge clk) wordWidth <= r[0];
      send('{8'h62, {2'b01, r[2:0], r[2:0]}, 8'h80});
      chk(eaTerms, ea[r], "ea terms");
      chk(dispVal, 16'hFF80, "short disp");
      chk(regSel, {~r[0], r[2:0]}, "reg map");
      chk(segSel, ea[r][2] ? `LOD_SEG_SS : `LOD_SEG_DS, "default seg");
      accept();
    end
    send('{8'h62, 8'h8F, 8'h34, 8'h12});
    chk(dispVal, 16'h1234, "long disp");
    accept();
    send('{8'h62, 8'h0E, 8'h78, 8'h56});
    chk(eaDirect, 1'b1, "direct");
    chk(dispVal, 16'h5678, "direct addr");
    chk(segSel, `LOD_SEG_DS, "direct seg");
    accept();
    send('{8'h62, 8'h02});
    chk(dispVal, 16'h0000, "no disp");
    chk(segSel, `LOD_SEG_SS, "frame seg");
    accept();
    send('{8'h63, 8'hCA});
    chk(eaIsReg, 1'b1, "reg form");
    chk(rmSel, 4'h2, "rm reg");
    accept();
    $display("test address done");
  endtask
  task automatic t_segment;
    for (int s = 0; s < 4; s++) begin
      send('{{3'b001, s[1:0], 3'b110}, 8'h62, 8'h46, 8'h10});
      chk(segSel, s[1:0], "override");
      accept();
    end
    @(posedge clk) strDest <= 1'b1;
    send('{8'h3E, 8'h62, 8'h05});
    chk(segSel, `LOD_SEG_ES, "string dest");
    accept();
    @(posedge clk) strDest <= 1'b0;
    $display("test segment done");
  endtask
  task automatic t_escape;
    for (int t = 0; t < 8; t++) begin
      send('{{5'h1B, t[2:0]}, {2'b11, ~t[2:0], 3'b000}});
      chk(opId, `LOD_ID_ESC, "escape");
      chk(escCode, {t[2:0], ~t[2:0]}, "esc code");
      accept();
    end
    $display("test escape done");
  endtask
  task automatic t_undef;
    send('{8'h00});
    chk(undefOp, 1'b1, "undef byte");
    accept();
    send('{8'h0F, 8'h07});
    chk(undefOp, 1'b1, "undef ext");
    accept();
    send('{8'hC3});
    chk(undefOp, 1'b0, "defined");
    accept();
    $display("test undefined done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(segSel, `LOD_SEG_DS, "reset seg");
    chk(byteReady, 1'b1, "reset ready");
    chk(decValid, 1'b0, "reset idle");
    t_returns();
    t_branches();
    t_frames();
    t_control();
    t_protect();
    t_address();
    t_segment();
    t_escape();
    t_undef();
    end_of_test();
  end
endmodule // lod_decoder_tb_top
